// ==== verilog/sbw_host.sv ====
// host end: issues indexed byte/word reads and writes
`timescale 1ns/10ps
`include "sbw_map.svh"
module sbw_host #(
  parameter logic [6:0] DEV_ADDR = `SBW_DEV_ADDR,
  parameter int QTR_CYC = `SBW_QTR_CYC
) (
  input wire logic clock,
  input wire logic rst,
  sbw_link_if.host lk,
  input wire logic req,
  input wire logic req_write,
  input wire logic req_word,
  input wire logic [6:0] req_off,
  input wire logic [15:0] req_wdata,
  output logic busy,
  output logic done,
  output logic nack,
  output logic [15:0] rdata
);

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0] sda_sy;
    logic [15:0] div;
    sbw_pkg::sbw_hstate_t st;
    sbw_pkg::sbw_phase_t ph;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic ackbit;
    logic wr;
    logic word;
    logic [6:0] off;
    logic [15:0] wdata;
    logic scl;
    logic sda_oe;
    logic busy;
    logic done;
    logic nack;
    logic [15:0] rdata;
  } sbw_host_reg_t;

  sbw_host_reg_t r_r;
  sbw_host_reg_t r_nxt;
  logic tick;
  logic sda_s;
  logic txing;
  logic last;

  assign sda_s = r_r.sda_sy[1];
  assign tick = (r_r.div == 16'(QTR_CYC - 1));
  assign txing = (r_r.ph != sbw_pkg::HP_RLO) && (r_r.ph != sbw_pkg::HP_RHI);
  assign last = (r_r.bitn == `SBW_BYTE_BITS);
  assign lk.scl = r_r.scl;
  assign lk.h_sda_o = 1'b0;
  assign lk.h_sda_oe = r_r.sda_oe;
  assign busy = r_r.busy;
  assign done = r_r.done;
  assign nack = r_r.nack;
  assign rdata = r_r.rdata;

  //////////////////////////////////////////////////////////////////////////////
  // each bit is four quarters: low/set data, high, high/sample, low
  always_comb begin
    r_nxt = r_r;
    r_nxt.sda_sy = {r_r.sda_sy[0], lk.sda};
    r_nxt.done = 1'b0;
    r_nxt.div = tick ? 16'h0000 : r_r.div + 16'h0001;
    if (tick && r_r.st != sbw_pkg::H_IDLE) begin
      r_nxt.q = r_r.q + 2'h1;
    end
    case (r_r.st)
      sbw_pkg::H_IDLE: begin
        r_nxt.scl = 1'b1;
        r_nxt.sda_oe = 1'b0;
        if (req) begin
          r_nxt.st = sbw_pkg::H_START; // R1
          r_nxt.ph = sbw_pkg::HP_AW;
          r_nxt.q = 2'h0;
          r_nxt.div = 16'h0000;
          r_nxt.busy = 1'b1;
          r_nxt.nack = 1'b0;
          r_nxt.wr = req_write;
          r_nxt.word = req_word;
          r_nxt.off = req_off;
          r_nxt.wdata = req_wdata;
        end
      end
      sbw_pkg::H_START: begin
        if (tick) begin
          case (r_r.q)
            2'h0: r_nxt.scl = 1'b0;
            2'h1: r_nxt.scl = 1'b1;
            2'h2: r_nxt.sda_oe = 1'b1;
            default: begin
              r_nxt.scl = 1'b0;
              r_nxt.st = sbw_pkg::H_BYTE;
              r_nxt.bitn = 4'h0;
              r_nxt.sh = {DEV_ADDR, r_r.ph == sbw_pkg::HP_AR}; // R1 R4
            end
          endcase
          if (r_r.q == 2'h0) begin
            r_nxt.sda_oe = 1'b0;
          end
        end
      end
      sbw_pkg::H_BYTE: begin
        if (tick) begin
          case (r_r.q)
            2'h0: begin
              r_nxt.scl = 1'b0;
              if (!last) begin
                r_nxt.sda_oe = txing & ~r_r.sh[7];
              end else begin
                // ack the low byte of a word read, nack the final byte
                r_nxt.sda_oe = ~txing & r_r.word & (r_r.ph == sbw_pkg::HP_RLO); // R4 R5 R7
              end
            end
            2'h1: r_nxt.scl = 1'b1;
            2'h2: begin
              if (last) begin
                r_nxt.ackbit = sda_s;
              end else if (!txing) begin
                r_nxt.sh = {r_r.sh[6:0], sda_s};
              end
            end
            default: begin
              r_nxt.scl = 1'b0;
              r_nxt.bitn = r_r.bitn + 4'h1;
              if (!last && txing) begin
                r_nxt.sh = {r_r.sh[6:0], 1'b0};
              end
              if (last) begin
                r_nxt.bitn = 4'h0;
                if (txing && r_r.ackbit) begin
                  r_nxt.nack = 1'b1;
                  r_nxt.st = sbw_pkg::H_STOP;
                end else begin
                  case (r_r.ph)
                    sbw_pkg::HP_AW: begin
                      r_nxt.ph = sbw_pkg::HP_CMD;
                      r_nxt.sh = {1'b1, r_r.off}; // R1 R2
                    end
                    sbw_pkg::HP_CMD: begin
                      if (r_r.wr) begin
                        r_nxt.ph = sbw_pkg::HP_WLO; // R3 R6
                        r_nxt.sh = r_r.wdata[7:0];
                      end else begin
                        r_nxt.ph = sbw_pkg::HP_AR; // R4
                        r_nxt.st = sbw_pkg::H_START;
                      end
                    end
                    sbw_pkg::HP_WLO: begin
                      if (r_r.word) begin
                        r_nxt.ph = sbw_pkg::HP_WHI; // R3
                        r_nxt.sh = r_r.wdata[15:8];
                      end else begin
                        r_nxt.st = sbw_pkg::H_STOP; // R6
                      end
                    end
                    sbw_pkg::HP_AR: r_nxt.ph = sbw_pkg::HP_RLO;
                    sbw_pkg::HP_RLO: begin
                      r_nxt.rdata[7:0] = r_r.sh;
                      if (r_r.word) begin
                        r_nxt.ph = sbw_pkg::HP_RHI; // R5
                      end else begin
                        r_nxt.st = sbw_pkg::H_STOP; // R7
                      end
                    end
                    sbw_pkg::HP_RHI: begin
                      r_nxt.rdata[15:8] = r_r.sh;
                      r_nxt.st = sbw_pkg::H_STOP; // R5
                    end
                    default: r_nxt.st = sbw_pkg::H_STOP;
                  endcase
                end
              end
            end
          endcase
        end
      end
      sbw_pkg::H_STOP: begin
        if (tick) begin
          case (r_r.q)
            2'h0: begin
              r_nxt.scl = 1'b0;
              r_nxt.sda_oe = 1'b1;
            end
            2'h1: r_nxt.scl = 1'b1;
            2'h2: r_nxt.sda_oe = 1'b0; // R3 R5 R6 R7
            default: begin
              r_nxt.st = sbw_pkg::H_IDLE;
              r_nxt.busy = 1'b0;
              r_nxt.done = 1'b1;
            end
          endcase
        end
      end
      default: r_nxt.st = sbw_pkg::H_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (rst) begin
      r_r <= '{sda_sy: 2'h3, st: sbw_pkg::H_IDLE, ph: sbw_pkg::HP_AW, scl: 1'b1,
               default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

endmodule

// ==== verilog/sbw_map.svh ====
// constants of the indexed byte/word smbus slave and its host
// Functional notes
// R1: start, address+write, acked indexed command byte
// R2: command bits 6:0 give byte offset
// R3: word write: low, high, acked, stop
// R4: word read: restart, address+read, low byte acked
// R5: word read: high byte, host nack, stop
// R6: byte write: one acked byte, stop
// R7: byte read: one byte, host nack, stop
// R8: command bit 7 clear selects block access
// R9: word high byte lives at next offset
`ifndef SBW_MAP_SVH
`define SBW_MAP_SVH
`define SBW_ADDR_W 7
`define SBW_OFF_W 7
`define SBW_IDX_BIT 7
`define SBW_BYTE_BITS 4'h8
`define SBW_CFG_DEPTH 128
`define SBW_DEV_ADDR 7'h5a
`define SBW_BLK_COUNT 8'h08
`define SBW_CLK_HZ 40000000
`define SBW_SCL_HZ 100000
`define SBW_QTR_CYC (`SBW_CLK_HZ / (4 * `SBW_SCL_HZ))
`endif

// ==== verilog/sbw_pkg.sv ====
// types of the two ends of the link: device states and kinds, host states and phases
package sbw_pkg;
  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_MACK, D_WAIT} sbw_dstate_t;
  typedef enum logic [1:0] {K_ADDR, K_CMD, K_DATA} sbw_kind_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} sbw_hstate_t;
  typedef enum logic [2:0] {HP_AW, HP_CMD, HP_WLO, HP_WHI, HP_AR, HP_RLO, HP_RHI} sbw_phase_t;
endpackage

// ==== verilog/sbw_link_if.sv ====
// two-wire link between host and device
`timescale 1ns/10ps
interface sbw_link_if;
  logic scl;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic sda;
  // open-drain wired-and with pull-up
  assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
  modport host (output scl, output h_sda_o, output h_sda_oe, input sda);
  modport dev (input scl, output d_sda_o, output d_sda_oe, input sda);
endinterface

// ==== verilog/sbw_dev.sv ====
// device end: indexed byte/word slave with configuration bytes
`timescale 1ns/10ps
`include "sbw_map.svh"
module sbw_dev #(
  parameter logic [6:0] DEV_ADDR = `SBW_DEV_ADDR,
  parameter logic [7:0] BLK_COUNT = `SBW_BLK_COUNT
) (
  input wire logic link_clock,
  input wire logic rst,
  sbw_link_if.dev lk,
  input wire logic [6:0] rd_off,
  output logic [7:0] rd_data,
  output logic wr_stb,
  output logic [6:0] wr_off,
  output logic [7:0] wr_data
);

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_p;
    logic sda_p;
    sbw_pkg::sbw_dstate_t st;
    sbw_pkg::sbw_kind_t kind;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rd;
    logic blk_pend;
    logic [6:0] ptr;
    logic sda_oe;
    logic wr_stb;
    logic [6:0] wr_off;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
  } sbw_dev_reg_t;

  sbw_dev_reg_t r_r;
  sbw_dev_reg_t r_nxt;
  logic [7:0] cfg_mem [`SBW_CFG_DEPTH];
  logic mem_we;
  logic [6:0] mem_wa;
  logic [7:0] mem_wd;
  logic scl_s;
  logic sda_s;
  logic rise;
  logic fall;
  logic start_det;
  logic stop_det;
  logic [7:0] tx_byte;

  //////////////////////////////////////////////////////////////////////////////
  // only the second sync stage feeds any logic
  assign scl_s = r_r.scl_sy[1];
  assign sda_s = r_r.sda_sy[1];
  assign rise = scl_s & ~r_r.scl_p;
  assign fall = ~scl_s & r_r.scl_p;
  assign start_det = scl_s & r_r.scl_p & r_r.sda_p & ~sda_s;
  assign stop_det = scl_s & r_r.scl_p & ~r_r.sda_p & sda_s;
  // block reads lead with the byte count
  assign tx_byte = r_r.blk_pend ? BLK_COUNT : cfg_mem[r_r.ptr]; // R8

  assign lk.d_sda_o = 1'b0;
  assign lk.d_sda_oe = r_r.sda_oe;
  assign rd_data = r_r.rd_data;
  assign wr_stb = r_r.wr_stb;
  assign wr_off = r_r.wr_off;
  assign wr_data = r_r.wr_data;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_nxt = r_r;
    mem_we = 1'b0;
    mem_wa = r_r.ptr;
    mem_wd = r_r.sh;
    r_nxt.scl_sy = {r_r.scl_sy[0], lk.scl};
    r_nxt.sda_sy = {r_r.sda_sy[0], lk.sda};
    r_nxt.scl_p = scl_s;
    r_nxt.sda_p = sda_s;
    r_nxt.wr_stb = 1'b0;
    r_nxt.rd_data = cfg_mem[rd_off];
    if (start_det) begin
      // repeated start keeps the offset taken from the command
      r_nxt.st = sbw_pkg::D_RX; // R1 R4
      r_nxt.kind = sbw_pkg::K_ADDR;
      r_nxt.cnt = 4'h0;
      r_nxt.sda_oe = 1'b0;
    end else if (stop_det) begin
      r_nxt.st = sbw_pkg::D_IDLE;
      r_nxt.sda_oe = 1'b0;
    end else begin
      case (r_r.st)
        sbw_pkg::D_RX: begin
          if (rise) begin
            r_nxt.sh = {r_r.sh[6:0], sda_s};
            r_nxt.cnt = r_r.cnt + 4'h1;
          end else if (fall && r_r.cnt == `SBW_BYTE_BITS) begin
            r_nxt.st = sbw_pkg::D_ACK;
            r_nxt.sda_oe = 1'b1;
            case (r_r.kind)
              sbw_pkg::K_ADDR: begin
                // a foreign address is left alone until the next start
                if (r_r.sh[7:1] == DEV_ADDR) begin
                  r_nxt.rd = r_r.sh[0]; // R1 R4
                end else begin
                  r_nxt.st = sbw_pkg::D_WAIT;
                  r_nxt.sda_oe = 1'b0;
                end
              end
              sbw_pkg::K_CMD: begin
                r_nxt.blk_pend = ~r_r.sh[`SBW_IDX_BIT]; // R8
                if (r_r.sh[`SBW_IDX_BIT]) begin
                  r_nxt.ptr = r_r.sh[`SBW_OFF_W - 1:0]; // R2
                end else begin
                  r_nxt.ptr = 7'h00; // R8
                end
              end
              default: begin
                if (r_r.blk_pend) begin
                  // block byte count is taken and dropped
                  r_nxt.blk_pend = 1'b0; // R8
                end else begin
                  mem_we = 1'b1; // R3 R6
                  r_nxt.wr_stb = 1'b1;
                  r_nxt.wr_off = r_r.ptr;
                  r_nxt.wr_data = r_r.sh;
                  r_nxt.ptr = r_r.ptr + 7'h01; // R9
                end
              end
            endcase
          end
        end
        sbw_pkg::D_ACK: begin
          if (fall) begin
            r_nxt.cnt = 4'h0;
            if (r_r.rd && r_r.kind == sbw_pkg::K_ADDR) begin
              r_nxt.st = sbw_pkg::D_TX; // R4 R7
              r_nxt.sh = tx_byte;
              r_nxt.sda_oe = ~tx_byte[7];
              r_nxt.blk_pend = 1'b0;
              if (!r_r.blk_pend) begin
                r_nxt.ptr = r_r.ptr + 7'h01;
              end
            end else begin
              r_nxt.st = sbw_pkg::D_RX;
              r_nxt.sda_oe = 1'b0;
              if (r_r.kind == sbw_pkg::K_ADDR) begin
                r_nxt.kind = sbw_pkg::K_CMD;
              end else begin
                r_nxt.kind = sbw_pkg::K_DATA;
              end
            end
          end
        end
        sbw_pkg::D_TX: begin
          if (rise) begin
            r_nxt.cnt = r_r.cnt + 4'h1;
          end else if (fall) begin
            if (r_r.cnt == `SBW_BYTE_BITS) begin
              r_nxt.st = sbw_pkg::D_MACK;
              r_nxt.sda_oe = 1'b0;
            end else begin
              r_nxt.sh = {r_r.sh[6:0], 1'b0};
              r_nxt.sda_oe = ~r_r.sh[6];
            end
          end
        end
        sbw_pkg::D_MACK: begin
          if (rise && sda_s) begin
            // nack ends the read; wait for the stop
            r_nxt.st = sbw_pkg::D_WAIT; // R5 R7
          end else if (fall) begin
            // ack asks for the next byte: high byte at the next offset
            r_nxt.st = sbw_pkg::D_TX; // R5 R9
            r_nxt.cnt = 4'h0;
            r_nxt.sh = tx_byte;
            r_nxt.sda_oe = ~tx_byte[7];
            r_nxt.blk_pend = 1'b0;
            if (!r_r.blk_pend) begin
              r_nxt.ptr = r_r.ptr + 7'h01;
            end
          end
        end
        sbw_pkg::D_IDLE, sbw_pkg::D_WAIT: begin
          r_nxt.sda_oe = 1'b0;
        end
        default: begin
          r_nxt.st = sbw_pkg::D_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge link_clock) begin
    if (rst) begin
      r_r <= '{scl_sy: 2'h3, sda_sy: 2'h3, scl_p: 1'b1, sda_p: 1'b1,
               st: sbw_pkg::D_IDLE, kind: sbw_pkg::K_ADDR, default: '0};
      for (int i = 0; i < `SBW_CFG_DEPTH; i++) begin
        cfg_mem[i] <= 8'h00;
      end
    end else begin
      r_r <= r_nxt;
      if (mem_we) begin
        cfg_mem[mem_wa] <= mem_wd;
      end
    end
  end

endmodule

// ==== verification/sbw_link_assertions.sv ====
// checker of the two-wire link, sampled on the device clock
`timescale 1ns/10ps
module sbw_link_assertions #(
  parameter int QTR_CYC = 4
) (
  input wire logic link_clock,
  input wire logic rst,
  input wire logic scl,
  input wire logic h_sda_o,
  input wire logic h_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic sda
);
  int cnt_lo_r;
  int cnt_oe_r;
  // counters instead of long repetitions, which the tools unroll badly
  always_ff @(posedge link_clock) begin
    if (rst) begin
      cnt_lo_r <= 0;
      cnt_oe_r <= 0;
    end else begin
      cnt_lo_r <= scl ? 0 : cnt_lo_r + 1;
      cnt_oe_r <= d_sda_oe ? cnt_oe_r + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge link_clock);
  endclocking
  default disable iff (rst);
  AST_HOST_OPEN_DRAIN: assert property (h_sda_oe |-> !h_sda_o)
    else $error("host drives sda high");
  AST_DEV_OPEN_DRAIN: assert property (d_sda_oe |-> !d_sda_o)
    else $error("device drives sda high");
  AST_DEV_TAKE_LOW: assert property ($rose(d_sda_oe) |-> !scl)
    else $error("device grabs sda while scl high");
  AST_DEV_DROP_LOW: assert property ($fell(d_sda_oe) |-> !scl)
    else $error("device lets go of sda while scl high");
  AST_SCL_HI_MIN: assert property ($rose(scl) |=> scl [*4])
    else $error("scl high phase too short");
  AST_SCL_LO_MIN: assert property ($fell(scl) |=> !scl [*4])
    else $error("scl low phase too short");
  AST_SCL_LO_MAX: assert property (cnt_lo_r <= 8 * QTR_CYC)
    else $error("scl held low too long");
  AST_DEV_OE_MAX: assert property (cnt_oe_r <= 80 * QTR_CYC)
    else $error("device holds sda too long");
  AST_STOP_FREE: assert property ((scl && $past(scl) && $rose(sda)) |-> !d_sda_oe)
    else $error("device drives sda at stop");
  cover property ($rose(d_sda_oe));
  cover property (scl && $past(scl) && $fell(sda));
  cover property (scl && $past(scl) && $rose(sda));
endmodule

// ==== verification/test_smbus_byte_word_slave.sv ====
// bench: host and device joined over the link, driven from the host user port
`timescale 1ns/10ps
module test_smbus_byte_word_slave;
  localparam int QTR = 4;
  logic clock = 1'b0;
  logic link_clock = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic req_word = 1'b0;
  logic [6:0] req_off = 7'h00;
  logic [15:0] req_wdata = 16'h0000;
  logic [6:0] rd_off = 7'h00;
  logic busy, done, nack, wr_stb;
  logic [15:0] rdata;
  logic [7:0] rd_data, wr_data;
  logic [6:0] wr_off;
  logic [14:0] wlog[$];
  int bad_count = 0;
  int check_count = 0;
  int scl_rises = 0;
  always #12.5 clock = ~clock;
  // phase offset keeps the two clocks unrelated
  initial begin
    #4.1;
    forever #7.5 link_clock = ~link_clock;
  end
  ////////////////////////////////////////////////////////////////
  sbw_link_if lk();
  sbw_host #(.QTR_CYC(QTR)) sbw_host_i (.clock(clock), .rst(rst), .lk(lk), .req(req),
    .req_write(req_write), .req_word(req_word), .req_off(req_off), .req_wdata(req_wdata),
    .busy(busy), .done(done), .nack(nack), .rdata(rdata));
  sbw_dev sbw_dev_i (.link_clock(link_clock), .rst(rst), .lk(lk), .rd_off(rd_off),
    .rd_data(rd_data), .wr_stb(wr_stb), .wr_off(wr_off), .wr_data(wr_data));
  sbw_link_assertions #(.QTR_CYC(QTR)) sbw_link_assertions_i (.link_clock(link_clock),
    .rst(rst), .scl(lk.scl), .h_sda_o(lk.h_sda_o), .h_sda_oe(lk.h_sda_oe),
    .d_sda_o(lk.d_sda_o), .d_sda_oe(lk.d_sda_oe), .sda(lk.sda));
  // negedge sampling avoids racing the device's own update
  always @(negedge link_clock) begin
    if (wr_stb === 1'b1) begin
      wlog.push_back({wr_off, wr_data});
    end
  end
  always @(posedge lk.scl) scl_rises++;
  ////////////////////////////////////////////////////////////////
  task automatic chk_flag(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic [15:0] wpop();
    logic [15:0] v;
    v = 16'hffff;
    if (wlog.size() > 0) begin
      v = {1'b0, wlog.pop_front()};
    end
    return v;
  endfunction
  // one host transfer; bits is the expected number of scl pulses in it
  task automatic xfer(input logic w, input logic wd, input logic [6:0] off,
      input logic [15:0] d, input int bits);
    int n;
    @(negedge clock);
    req = 1'b1;
    req_write = w;
    req_word = wd;
    req_off = off;
    req_wdata = d;
    scl_rises = 0;
    n = 0;
    // hold the request until taken, else it would be taken again at done
    while (busy !== 1'b1 && n < 8) begin
      @(posedge clock);
      #1;
      n++;
    end
    @(negedge clock);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk_flag("done", 1'b1, done);
    chk_flag("busy", 1'b0, busy);
    chk_flag("nack", 1'b0, nack);
    chk_val("scl pulses", bits[15:0], scl_rises[15:0]);
  endtask
  task automatic peek(input logic [6:0] off, input logic [7:0] exp);
    // the read port belongs to the device clock, so drive it off that clock's edge
    @(negedge link_clock);
    rd_off = off;
    repeat (3) @(negedge link_clock);
    chk_val("cfg byte", {8'h00, exp}, {8'h00, rd_data});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    xfer(1'b1, 1'b0, 7'h40, 16'h0096, 29);
    chk_val("stored", {1'b0, 7'h40, 8'h96}, wpop());
    peek(7'h40, 8'h96);
    xfer(1'b1, 1'b1, 7'h7f, 16'h1234, 38);
    chk_val("stored", {1'b0, 7'h7f, 8'h34}, wpop());
    chk_val("stored", {1'b0, 7'h00, 8'h12}, wpop());
    peek(7'h00, 8'h12);
    xfer(1'b0, 1'b0, 7'h40, 16'h0000, 39);
    chk_val("read byte", 16'h0096, {8'h00, rdata[7:0]});
    xfer(1'b0, 1'b1, 7'h7f, 16'h0000, 48);
    chk_val("read word", 16'h1234, rdata);
    xfer(1'b0, 1'b1, 7'h3f, 16'h0000, 48);
    chk_val("read word", 16'h9600, rdata);
    chk_val("spurious stores", 16'h0000, 16'(wlog.size()));
    summarize();
  end
  // watchdog: the transfers need about 3300 cycles
  initial begin
    #(25 * 10000);
    bad_count++;
    $display("[FAIL] watchdog expected finish seen hang");
    summarize();
  end
endmodule
